// >>> include/adc_seq_params.svh
// Constants for the converter start sequencer
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define REG_CTRL_A 4'h0
`define REG_CTRL_B 4'h4
`define REG_STATUS 4'h8
`define BIT_GO 0
`define BIT_CMP_EN 1
`define BIT_DIV_LO 2
`define BIT_DIV_HI 4
`define BIT_VR_LO 5
`define BIT_VR_HI 6
`define BIT_LSP 0
`define BIT_TRIG_HW 1
`define BIT_TRIG_WAIT 2
`define BIT_ONESHOT 3
`define BIT_SEQ 4
`define BIT_SCAN 5
`define CLK_MHZ 125
`define STAB_TIME_NS 1000
`define SUPPLY_WAIT_NS 1000
`define CONV_CYCLES 8'h40
`define IRQ_DELAY_CYCLES 8'h01
`define STAB_EXTRA_FAD 2
`define WAIT_START_DELAY 5'h01
`endif

// >>> include/adc_seq_pkg.sv
// Types for the converter start sequencer
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STAB = 3'h1,
    ST_DELAY = 3'h3,
    ST_CONV = 3'h2,
    ST_IRQ = 3'h6
  } seq_state_t;
endpackage

// >>> include/div_if.sv
// Clock divider hookup between sequencer and divider
`timescale 1ns/1ns
interface div_if;
  logic [2:0] sel;
  logic fad_en;
  logic sync;
  modport ctl(output sel, output sync, input fad_en);
  modport div(input sel, input sync, output fad_en);
endinterface

// >>> rtl/fad_divider.sv
// Conversion clock enable divider
`timescale 1ns/1ns
module fad_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  div_if.div d
);
  logic [4:0] cnt;
  logic [4:0] limit;
  // Codes 000..101 divide by 32,16,8,4,2,1
  assign limit = (d.sel > 3'h5) ? 5'h00 : 5'(6'h20 >> d.sel) - 5'h01;
  assign d.fad_en = (cnt >= limit);
  always_ff @(posedge clk_i) begin
    // Restart aligns conversion length to whole fAD periods
    if (rst_i || d.fad_en || d.sync) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
endmodule

// >>> rtl/adc_start_sequencer.sv
// Converter start sequencer with Wishbone control registers
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`include "adc_seq_params.svh"
module adc_start_sequencer #(
  parameter int STAB_NS = `STAB_TIME_NS,
  parameter int SUPPLY_NS = `SUPPLY_WAIT_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hw_trig_i,
  output logic comparator_enable_o,
  output logic conv_active_o,
  output logic conv_done_o,
  output adc_seq_pkg::seq_state_t state_o
);
  import adc_seq_pkg::*;
  localparam int STAB_CYC = (STAB_NS * `CLK_MHZ + 999) / 1000;
  localparam int SUP_CYC = (SUPPLY_NS * `CLK_MHZ + 999) / 1000;
  initial begin
    if (STAB_CYC < 1 || STAB_CYC > 4095 || SUP_CYC < 1 || SUP_CYC > 4095)
      $error("stabilization time out of range");
  end
  logic conversion_go_bit;
  logic comparator_enable;
  logic [2:0] clock_div_sel;
  logic [1:0] voltage_range_sel;
  logic low_speed_select;
  logic [4:0] conversion_op_select;
  seq_state_t state;
  seq_state_t next_state;
  logic [11:0] cnt;
  logic [1:0] fad_seen;
  logic stab_done;
  logic [11:0] since_en;
  logic [7:0] fad_cnt;
  logic follow_on;
  logic trig_s1, trig_s2, trig_s3;
  logic trig_lvl;
  div_if dif();
  fad_divider u_div (.clk_i(clk_i), .rst_i(rst_i), .d(dif));
  assign dif.sel = clock_div_sel;
  assign dif.sync = state != ST_CONV && next_state == ST_CONV;
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = acc && wb_we_i && wb_sel_i[0];
  wire wr_a = wr && (wb_adr_i == `REG_CTRL_A);
  wire wr_b = wr && (wb_adr_i == `REG_CTRL_B);
  // Edge counts once the second and third flops agree
  wire trig_edge = trig_s2 && trig_s3 && !trig_lvl;
  wire hw_mode = conversion_op_select[`BIT_TRIG_HW - 1];
  wire wait_mode = conversion_op_select[`BIT_TRIG_WAIT - 1];
  wire oneshot = conversion_op_select[`BIT_ONESHOT - 1];
  wire skip = follow_on && (conversion_op_select[`BIT_SEQ - 1] ||
                            conversion_op_select[`BIT_SCAN - 1]);
  wire stable = stab_done && (fad_seen == 2'h2);
  // No-wait start delay equals divide ratio minus one, at least one
  wire [4:0] nw_delay = (clock_div_sel >= 3'h4) ? 5'h01 :
                        5'(6'h20 >> clock_div_sel) - 5'h01;
  wire [4:0] start_delay = wait_mode ? `WAIT_START_DELAY : nw_delay;
  wire hw_go = hw_mode && wait_mode && trig_edge && state == ST_IDLE;
  wire hw_nw_go = hw_mode && !wait_mode && trig_edge && conversion_go_bit;
  wire sw_go = conversion_go_bit && !hw_mode && state == ST_IDLE;
  wire launch = (sw_go || hw_go || hw_nw_go) && state == ST_IDLE;
  wire done = state == ST_IRQ && dif.fad_en;
  wire keep_go = hw_mode && !wait_mode &&
                 (oneshot || conversion_op_select[`BIT_SEQ - 1]);
  wire need_stab = wait_mode || !stable;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (launch) next_state = skip ? ST_CONV :
                 (need_stab ? ST_STAB : ST_DELAY);
      ST_STAB: if (cnt == 12'h000 &&
                   (wait_mode || stable || !comparator_enable))
                 next_state = ST_DELAY;
      ST_DELAY: if (cnt == 12'h000) next_state = ST_CONV;
      ST_CONV: if (dif.fad_en && fad_cnt == `CONV_CYCLES - 8'h01)
                 next_state = ST_IRQ;
      ST_IRQ: if (dif.fad_en) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (!conversion_go_bit && !hw_go) next_state = ST_IDLE;
  end
  always_ff @(posedge clk_i) begin
    trig_s1 <= hw_trig_i;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i)
      trig_lvl <= 1'b0;
    else if (trig_s2 == trig_s3)
      trig_lvl <= trig_s2;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= 12'h000;
      fad_cnt <= 8'h00;
      follow_on <= 1'b0;
    end else begin
      state <= next_state;
      if (state != next_state && next_state == ST_STAB)
        cnt <= 12'(SUP_CYC - 1);
      else if (state != next_state && next_state == ST_DELAY)
        cnt <= {7'h00, start_delay} - 12'h001;
      else if (cnt != 12'h000)
        cnt <= cnt - 12'h001;
      if (state != ST_CONV) fad_cnt <= 8'h00;
      else if (dif.fad_en) fad_cnt <= fad_cnt + 8'h01;
      if (done) follow_on <= 1'b1;
      else if (!conversion_go_bit) follow_on <= 1'b0;
    end
  end
  // Stabilization counter runs from the enable edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !comparator_enable) begin
      since_en <= 12'h000;
      stab_done <= 1'b0;
      fad_seen <= 2'h0;
    end else begin
      if (!stab_done) since_en <= since_en + 12'h001;
      if (since_en == 12'(STAB_CYC - 1)) stab_done <= 1'b1;
      if (stab_done && dif.fad_en && fad_seen != 2'h2)
        fad_seen <= fad_seen + 2'h1;
    end
  end
  // Enable write ignored while go set; keeps the comparator steady
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_go_bit <= 1'b0;
      comparator_enable <= 1'b0;
      clock_div_sel <= 3'h0;
      voltage_range_sel <= 2'h0;
      low_speed_select <= 1'b0;
      conversion_op_select <= 5'h00;
    end else begin
      if (wr_a) begin
        conversion_go_bit <= wb_dat_i[`BIT_GO];
        if (!conversion_go_bit)
          comparator_enable <= wb_dat_i[`BIT_CMP_EN];
        clock_div_sel <= wb_dat_i[`BIT_DIV_HI:`BIT_DIV_LO];
        voltage_range_sel <= wb_dat_i[`BIT_VR_HI:`BIT_VR_LO];
      end
      if (wr_b) begin
        low_speed_select <= wb_dat_i[`BIT_LSP];
        conversion_op_select <= wb_dat_i[`BIT_SCAN:`BIT_TRIG_HW];
      end
      // Hardware set wins over a same-cycle clear
      if (hw_go) conversion_go_bit <= 1'b1;
      else if (done && !keep_go && !(hw_mode && wait_mode))
        conversion_go_bit <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      conv_done_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
      conv_done_o <= done;
      case (wb_adr_i)
        `REG_CTRL_A: wb_dat_o <= {25'h0, voltage_range_sel, clock_div_sel,
                                  comparator_enable, conversion_go_bit};
        `REG_CTRL_B: wb_dat_o <= {26'h0, conversion_op_select,
                                  low_speed_select};
        `REG_STATUS: wb_dat_o <= {28'h0, stable, state};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  // Comparator runs through any started conversion
  assign comparator_enable_o = comparator_enable || state != ST_IDLE;
  assign conv_active_o = state == ST_CONV;
  assign state_o = state;
  conv_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_IRQ) |-> $past(fad_cnt) == 8'h3f)
    else $error("conversion length wrong");
  reset_idle_a: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> !conversion_go_bit && !comparator_enable)
    else $error("reset state wrong");
  hw_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_go |=> conversion_go_bit)
    else $error("trigger did not set go");
  keep_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done && keep_go && !wr_a |=> conversion_go_bit)
    else $error("one-shot go cleared");
  wait_dly_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_DELAY) && wait_mode |=> state != ST_DELAY)
    else $error("wait delay not one cycle");
  stab_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && launch && !stable && !skip |=> state == ST_STAB)
    else $error("stabilization skipped");
  skip_dly_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && launch && skip |=> state == ST_CONV)
    else $error("follow-on not skipped");
  nw_dly_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_DELAY) && !wait_mode && clock_div_sel == 3'h3
    && conversion_go_bit |-> (state == ST_DELAY)[*3])
    else $error("no-wait delay wrong");
  cmp_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_CONV |-> comparator_enable_o || $past(state) == ST_DELAY)
    else $error("comparator off in conversion");
endmodule

// >>> verif/trig_source.sv
// Hardware trigger source model for the sequencer
`timescale 1ns/1ns
module trig_source #(
  parameter int GAP = 200
) (
  input wire logic clk_i,
  input wire logic fire_i,
  output logic trig_o
);
  int hold = 0;
  int gap = 0;
  initial trig_o = 1'b0;
  always @(posedge clk_i) begin
    // Wide pulse so the three-flop synchronizer sees it
    trig_o <= hold > 0;
    hold <= hold > 0 ? hold - 1 : (fire_i && gap == 0 ? 4 : 0);
    // Too-close requests are dropped
    gap <= fire_i && gap == 0 ? GAP : (gap > 0 ? gap - 1 : 0);
  end
endmodule

// >>> verif/adc_start_sequencer_tb.sv
// Self-checking bench for the converter start sequencer
`timescale 1ns/1ns
module adc_start_sequencer_tb;
  import adc_seq_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic fire = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack, trig, cmp_o, act, done, saw_stab, saw_dly;
  seq_state_t st;
  int n_mismatch = 0;
  int total_checks = 0;
  always #4 clk_i = ~clk_i;
  // Short stabilization keeps the run brief
  adc_start_sequencer #(.STAB_NS(16), .SUPPLY_NS(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .hw_trig_i(trig),
    .comparator_enable_o(cmp_o), .conv_active_o(act),
    .conv_done_o(done), .state_o(st));
  trig_source #(.GAP(200)) src (.clk_i(clk_i), .fire_i(fire),
    .trig_o(trig));
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task hang(input int n);
    if (n >= 3000) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 3000);
    rd = dat_o;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    hang(n);
  endtask
  task pulse;
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task conv_rise;
    int n;
    n = 0;
    saw_stab = 0;
    saw_dly = 0;
    while (act !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
      saw_stab |= st === ST_STAB;
      saw_dly |= st === ST_DELAY;
    end
    hang(n);
  endtask
  // Zero length skips the length compare
  task conv_end(input int len);
    int n;
    n = 0;
    while (act === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (len > 0)
      chk(32'(n), 32'(len));
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(32'(done), 32'h1);
  endtask
  // Stop, then respect the restart gap
  task stop;
    wb(1'b1, 4'h0, 32'h0);
    repeat (640) @(posedge clk_i);
  endtask
  task t_reset;
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    chk(32'(cmp_o), 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_warm;
    wb(1'b1, 4'h0, 32'h14);
    wb(1'b1, 4'h0, 32'h16);
    chk(32'(cmp_o), 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk(32'(rd[3]), 32'h0);
    repeat (40) @(posedge clk_i);
    wb(1'b0, 4'h8, 32'h0);
    chk(32'(rd[3]), 32'h1);
    wb(1'b1, 4'h0, 32'h17);
    conv_rise();
    chk(32'(saw_stab), 32'h0);
    conv_end(64);
    wb(1'b0, 4'h0, 32'h0);
    chk(32'(rd[1:0]), 32'h2);
    stop();
  endtask
  task t_cold;
    wb(1'b1, 4'h0, 32'h0c);
    wb(1'b1, 4'h0, 32'h0d);
    conv_rise();
    chk(32'(saw_stab), 32'h1);
    chk(32'(cmp_o), 32'h1);
    conv_end(256);
    stop();
  endtask
  task t_hw_wait;
    wb(1'b1, 4'h4, 32'h6);
    wb(1'b1, 4'h0, 32'h14);
    pulse();
    conv_rise();
    wb(1'b0, 4'h0, 32'h0);
    chk(32'(rd[0]), 32'h1);
    conv_end(0);
    stop();
  endtask
  task t_oneshot;
    wb(1'b1, 4'h4, 32'ha);
    wb(1'b1, 4'h0, 32'h16);
    repeat (40) @(posedge clk_i);
    wb(1'b1, 4'h0, 32'h17);
    pulse();
    conv_rise();
    conv_end(64);
    wb(1'b0, 4'h0, 32'h0);
    chk(32'(rd[0]), 32'h1);
    stop();
  endtask
  task t_seq;
    wb(1'b1, 4'h4, 32'h12);
    wb(1'b1, 4'h0, 32'h16);
    repeat (40) @(posedge clk_i);
    wb(1'b1, 4'h0, 32'h17);
    pulse();
    conv_rise();
    conv_end(64);
    repeat (200) @(posedge clk_i);
    pulse();
    conv_rise();
    chk(32'(saw_dly | saw_stab), 32'h0);
    conv_end(64);
    stop();
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_warm();
    t_cold();
    t_hw_wait();
    t_oneshot();
    t_seq();
    final_report();
  end
endmodule
